//--- rtl/pfs_top.sv
// Sequencer, group control, fault handling and phase clocks of the power supervisor.
// Assumes raw analog comparator outputs and pins; all are synchronised to clk here.
`timescale 1ns/1ps
module pfs_top
	import pfs_pkg::*;
#(
	parameter int TMO = TMO_CYC
)(
	input  wire logic        clk,
	input  wire logic        rst_b,
	input  wire logic        por_in,
	input  wire logic [1:0]  ss_cfg_in,
	input  wire logic [1:0]  frequency_config_input,
	input  wire logic [7:0]  therm_in,
	input  wire logic [7:0]  oc_in,
	input  wire logic [7:0]  sc_in,
	input  wire logic [7:0]  ovuv_in,
	input  wire logic [7:0]  pg_in,
	input  wire logic        scl_in,
	input  wire logic        sda_in,
	output logic             sda_out,
	output logic             sda_oe_b,
	output logic             rst_out,
	output logic             rst_oe_b,
	output logic [7:0]       rail_en,
	output logic [7:0]       cur_lim,
	output logic [15:0]      ss_time,
	output logic [3:0]       phase_clk,
	output logic             second_switching_frequency
);
	localparam int TW = $clog2(TMO + 1);

	// ******************************************************
	// Input synchronisers
	// ******************************************************
	logic [44:0] s1_r;
	logic [44:0] s2_r;
	logic        por_s;
	logic [1:0]  ss_s;
	logic [1:0]  fq_s;
	logic [7:0]  th_s;
	logic [7:0]  oc_s;
	logic [7:0]  sc_s;
	logic [7:0]  ov_s;
	logic [7:0]  pg_s;

	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			s1_r <= '0;
			s2_r <= '0;
		end
		else
		begin
			s1_r <= {por_in, ss_cfg_in, frequency_config_input, therm_in, oc_in, sc_in, ovuv_in,
				pg_in};
			s2_r <= s1_r;
		end
	end
	assign {por_s, ss_s, fq_s, th_s, oc_s, sc_s, ov_s, pg_s} = s2_r;

	// ******************************************************
	// Host register file and accurate-mode check
	// ******************************************************
	logic       wr_stb;
	logic [7:0] wr_dat;
	logic [7:0] ptr;
	logic [7:0] rd_dat;
	logic       cmt;
	logic       pv_r;
	logic [7:0] pa_r;
	logic [7:0] pd_r;
	logic       acc_r;
	logic       seq_r;
	logic [3:0] grp_r;
	logic [7:0] ovm_r;
	logic [7:0] ss_hi_r;
	logic [3:0] second_switching_frequency_r;
	logic       done_r;
	logic [3:0] flags [8];
	logic [7:0] trip;
	logic [7:0] fsum;

	pfs_i2c u_i2c (
		.clk        (clk),
		.rst_b      (rst_b),
		.scl_in     (scl_in),
		.sda_in     (sda_in),
		.sda_oe_b_r (sda_oe_b),
		.wr_stb_r   (wr_stb),
		.wr_dat_r   (wr_dat),
		.ptr_r      (ptr),
		.rd_dat     (rd_dat)
	);

	// In accurate mode a write lands only when its second copy matches the first.
	assign cmt = wr_stb && (!acc_r || (pv_r && pa_r == ptr && pd_r == wr_dat));

	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			pv_r <= 1'b0;
			pa_r <= 8'h00;
			pd_r <= 8'h00;
		end
		else if (wr_stb && acc_r)
		begin
			pv_r <= !pv_r;
			pa_r <= ptr;
			pd_r <= wr_dat;
		end
	end

	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			acc_r  <= 1'b0;
			seq_r  <= 1'b0;
			grp_r  <= 4'h0;
			ovm_r  <= 8'h00;
			second_switching_frequency_r <= 4'h0;
		end
		else if (!por_s)
			grp_r <= 4'h0;
		else if (cmt)
		begin
			if (ptr == A_CTRL)
			begin
				acc_r <= wr_dat[B_ACC];
				seq_r <= wr_dat[B_SEQ];
			end
			if (ptr == A_GRP && done_r)
				grp_r <= wr_dat[3:0];
			if (ptr == A_OVM)
				ovm_r <= wr_dat;
			if (ptr == A_SECOND_SWITCHING_FREQUENCY && done_r)
				second_switching_frequency_r <= wr_dat[3:0];
		end
	end

	always_comb
	begin
		rd_dat = 8'h00;
		unique case (ptr)
		A_CTRL: rd_dat = {6'h00, seq_r, acc_r};
		A_GRP:  rd_dat = {4'h0, grp_r};
		A_OVM:  rd_dat = ovm_r;
		A_SS:   rd_dat = ss_hi_r;
		A_SECOND_SWITCHING_FREQUENCY: rd_dat = {4'h0, second_switching_frequency_r};
		A_FSUM: rd_dat = fsum;
		default:
			if (ptr[7:3] == A_FCH)
				rd_dat = {4'h0, flags[ptr[2:0]]};
		endcase
	end

	// ******************************************************
	// Per-rail fault channels
	// ******************************************************
	for (genvar i = 0; i < 8; i++)
	begin : g_ch
		logic [3:0] clr;
		assign clr = (cmt && ptr == {A_FCH, 3'(i)}) ? wr_dat[3:0] : 4'h0;
		// The third auxiliary rail has no thermal sensor.
		pfs_chan #(.TMO(TMO)) u_ch (
			.clk     (clk),
			.rst_b   (rst_b),
			.on      (rail_en[i]),
			.therm   ((i == X_AUXC) ? 1'b0 : th_s[i]),
			.oc      (oc_s[i]),
			.sc      (sc_s[i]),
			.ovuv    (ov_s[i]),
			.rep     (ovm_r[i]),
			.clr     (clr),
			.flags_r (flags[i]),
			.trip_r  (trip[i]),
			.cl_r    (cur_lim[i])
		);
		assign fsum[i] = |flags[i];
	end

	// ******************************************************
	// Start-up sequencer
	// ******************************************************
	pfs_sq_t       sq_r;
	pfs_sq_t       sq_nxt;
	logic [TW-1:0] tmr_r;
	logic          retry_r;
	logic          restart_r;
	logic          cpu_th;
	logic          cpu_ov;
	logic          cpu_sc;
	logic          cpu_kill;
	logic [1:0]    ss_def_r;
	logic [1:0]    fdiv_r;

	assign cpu_th   = |(th_s & rail_en & CPU_MASK);
	assign cpu_ov   = |(ov_s & rail_en & ~ovm_r & CPU_MASK);
	assign cpu_sc   = |(sc_s & rail_en & CPU_MASK);
	assign cpu_kill = cpu_th || cpu_ov || (|(trip & CPU_MASK) && !cpu_sc);

	always_comb
	begin
		sq_nxt = sq_r;
		if (!por_s)
			sq_nxt = SQ_OFF;
		else
			unique case (sq_r)
			SQ_OFF: sq_nxt = SQ_RAMP;
			SQ_RAMP, SQ_RUN:
				if (cpu_kill)
					sq_nxt = SQ_DOWN;
				else if (cpu_sc)
					sq_nxt = retry_r ? SQ_DOWN : SQ_RETRY;
				else if (sq_r == SQ_RAMP && &pg_s[X_CPUC:X_CPUA])
					sq_nxt = SQ_RUN;
			SQ_RETRY:
				if (tmr_r == TW'(TMO - 1))
					sq_nxt = SQ_RAMP;
			SQ_DOWN:
				if (restart_r && !(|(ov_s & CPU_MASK)))
					sq_nxt = SQ_RAMP;
			default: sq_nxt = SQ_OFF;
			endcase
	end

	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			sq_r      <= SQ_OFF;
			tmr_r     <= '0;
			retry_r   <= 1'b0;
			restart_r <= 1'b0;
			done_r    <= 1'b0;
		end
		else
		begin
			sq_r  <= sq_nxt;
			tmr_r <= (sq_r == SQ_RETRY) ? tmr_r + 1'b1 : '0;
			if (sq_r == SQ_OFF)
				retry_r <= 1'b0;
			else if (sq_nxt == SQ_RETRY)
				retry_r <= 1'b1;
			// Only a voltage cause may bring the device back by itself.
			if (sq_nxt == SQ_DOWN && sq_r != SQ_DOWN)
				restart_r <= cpu_ov && !cpu_th;
			if (sq_nxt == SQ_OFF)
				done_r <= 1'b0;
			else if (sq_nxt == SQ_RUN)
				done_r <= 1'b1;
		end
	end

	// Straps are caught on the clock edge that leaves the off state.
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			ss_def_r <= 2'h0;
			fdiv_r   <= 2'h0;
			ss_hi_r  <= 8'h00;
		end
		else if (sq_r == SQ_OFF && por_s)
		begin
			ss_def_r <= ss_s;
			fdiv_r   <= fq_s;
			ss_hi_r  <= {4{ss_s}};
		end
		else if (cmt && ptr == A_SS && done_r)
			ss_hi_r <= wr_dat;
	end

	// ******************************************************
	// Group control and reset output
	// ******************************************************
	logic [3:0] gf_r;
	logic [3:0] gf_set;
	logic [7:0] en_nxt;
	logic       run;
	logic       aux_ok;

	assign run    = sq_nxt == SQ_RUN;
	assign aux_ok = run && grp_r[G_AUX] && !gf_r[G_AUX];

	always_comb
	begin
		gf_set         = 4'h0;
		gf_set[G_MAIN] = trip[X_GATE];
		gf_set[G_AUX]  = trip[X_AUXB] || trip[X_AUXC] || (!seq_r && trip[X_AUXA]);
		gf_set[G_SPEC] = seq_r && trip[X_AUXA];
		gf_set[G_BL]   = trip[X_BL];
		en_nxt                  = 8'h00;
		en_nxt[X_GATE]          = run && grp_r[G_MAIN] && !gf_r[G_MAIN];
		en_nxt[X_CPUC:X_CPUA]   = {3{sq_nxt == SQ_RAMP || run}};
		en_nxt[X_AUXA]          = seq_r ? run && grp_r[G_SPEC] && !gf_r[G_SPEC] : aux_ok;
		en_nxt[X_AUXB]          = aux_ok && (!seq_r || pg_s[X_AUXC]);
		en_nxt[X_AUXC]          = aux_ok;
		en_nxt[X_BL]            = run && grp_r[G_BL] && !gf_r[G_BL];
		en_nxt                  = en_nxt & ~trip;
		if (|gf_set)
			en_nxt = en_nxt & ~{gf_set[G_BL], {2{gf_set[G_AUX]}},
				seq_r ? gf_set[G_SPEC] : gf_set[G_AUX], 3'h0, gf_set[G_MAIN]};
	end

	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			gf_r     <= 4'h0;
			rail_en  <= 8'h00;
			rst_oe_b <= 1'b0;
			rst_out  <= 1'b0;
			sda_out  <= 1'b0;
			ss_time  <= 16'h0000;
		end
		else
		begin
			// A group fault holds until the host takes the group enable away.
			gf_r     <= (gf_r & grp_r) | gf_set;
			rail_en  <= en_nxt;
			rst_oe_b <= run;
			rst_out  <= 1'b0;
			sda_out  <= 1'b0;
			ss_time  <= {ss_hi_r, {4{ss_def_r}}};
		end
	end

	// ******************************************************
	// Phase and second frequency clocks
	// ******************************************************
	logic [1:0] dcnt_r;
	logic [5:0] ph_r;
	logic [3:0] f2cnt_r;

	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			dcnt_r    <= 2'h0;
			ph_r      <= 6'h00;
			phase_clk <= 4'h0;
		end
		else
		begin
			dcnt_r <= (dcnt_r == fdiv_r) ? 2'h0 : dcnt_r + 2'h1;
			if (dcnt_r == fdiv_r)
				ph_r <= (ph_r == PH_STEPS - 6'h01) ? 6'h00 : ph_r + 6'h01;
			for (int k = 0; k < 4; k++)
				phase_clk[k] <= por_s && (((ph_r >= PH_OFF * 6'(k)) ? ph_r - PH_OFF * 6'(k)
					: ph_r + PH_STEPS - PH_OFF * 6'(k)) < PH_HALF);
		end
	end

	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			f2cnt_r                    <= 4'h0;
			second_switching_frequency <= 1'b0;
		end
		else if (f2cnt_r == second_switching_frequency_r)
		begin
			f2cnt_r                    <= 4'h0;
			second_switching_frequency <= por_s && !second_switching_frequency;
		end
		else
			f2cnt_r <= f2cnt_r + 4'h1;
	end

	// ******************************************************
	// Checks
	// ******************************************************
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_b);

	dev_therm_a: assert property ((sq_r == SQ_RUN) && cpu_th && por_s |=> sq_r == SQ_DOWN)
		else $error("processor rail thermal trip did not stop the device");
	sc_retry_a: assert property ((sq_r == SQ_RUN) && por_s && cpu_sc && !cpu_kill && !retry_r
		|=> sq_r == SQ_RETRY ##0 rail_en[X_CPUC:X_CPUA] == 3'h0)
		else $error("first short did not start one retry");
	retry_end_a: assert property ((sq_r == SQ_RETRY) && por_s && tmr_r == TW'(TMO - 1)
		|=> sq_r == SQ_RAMP)
		else $error("retry did not restart after its timeout");
	ov_restart_a: assert property ((sq_r == SQ_DOWN) && por_s && restart_r && !(|(ov_s & CPU_MASK))
		|=> sq_r == SQ_RAMP)
		else $error("voltage shutdown did not restart");
	rst_hold_a: assert property (rst_oe_b |-> sq_r == SQ_RUN && $past(&pg_s[X_CPUC:X_CPUA])
		|| $past(sq_r) == SQ_RUN)
		else $error("reset released before processor rails regulate");
	rst_drain_a: assert property (rst_out == 1'b0)
		else $error("reset output driven high");
	grp_gate_a: assert property (!done_r && !$past(done_r) |-> grp_r == 4'h0 && !rail_en[X_BL])
		else $error("group switched before power-up completed");
	acc_drop_a: assert property (wr_stb && acc_r && !(pv_r && pa_r == ptr && pd_r == wr_dat)
		|=> $stable(ovm_r) && $stable(seq_r))
		else $error("mismatched accurate copy was applied");
	grp_off_a: assert property ($rose(gf_r[G_AUX]) |-> rail_en[X_AUXC:X_AUXB] == 2'h0)
		else $error("auxiliary group not fully off after a trip");

	run_c: cover property (sq_r == SQ_RAMP ##1 sq_r == SQ_RUN);
	retry_c: cover property (sq_r == SQ_RETRY ##1 sq_r == SQ_RAMP);
	restart_c: cover property (sq_r == SQ_DOWN ##1 sq_r == SQ_RAMP);
	acc_c: cover property (cmt && acc_r);
endmodule

//--- rtl/pfs_pkg.sv
// Constants, state types and the host-visible register map of the power supervisor.
// Assumes a 20 MHz core clock and a host that talks to the block over I2C.
package pfs_pkg;
	localparam int CLK_HZ  = 20_000_000;
	localparam int TMO_MS  = 10;
	localparam int TMO_CYC = CLK_HZ / 1000 * TMO_MS;

	localparam logic [7:0] CPU_MASK = 8'h0E;
	localparam int X_GATE = 0;
	localparam int X_CPUA = 1;
	localparam int X_CPUC = 3;
	localparam int X_AUXA = 4;
	localparam int X_AUXB = 5;
	localparam int X_AUXC = 6;
	localparam int X_BL   = 7;

	localparam logic [7:0] A_CTRL = 8'h00;
	localparam logic [7:0] A_GRP  = 8'h01;
	localparam logic [7:0] A_OVM  = 8'h02;
	localparam logic [7:0] A_SS   = 8'h03;
	localparam logic [7:0] A_SECOND_SWITCHING_FREQUENCY = 8'h04;
	localparam logic [7:0] A_FSUM = 8'h05;
	localparam logic [4:0] A_FCH  = 5'h02;
	localparam int B_ACC = 0;
	localparam int B_SEQ = 1;
	localparam int G_MAIN = 0;
	localparam int G_AUX  = 1;
	localparam int G_BL   = 2;
	localparam int G_SPEC = 3;
	localparam int F_TH = 0;
	localparam int F_OC = 1;
	localparam int F_SC = 2;
	localparam int F_OV = 3;

	localparam logic [5:0] PH_STEPS = 6'h24;
	localparam logic [5:0] PH_OFF   = 6'h08;
	localparam logic [5:0] PH_HALF  = 6'h12;
	localparam logic [6:0] I2C_ADR  = 7'h2A;

	typedef enum logic [2:0] {
		SQ_OFF   = 3'b000,
		SQ_RAMP  = 3'b001,
		SQ_RUN   = 3'b010,
		SQ_RETRY = 3'b011,
		SQ_DOWN  = 3'b100
	} pfs_sq_t;

	typedef enum logic [2:0] {
		IC_IDLE = 3'b000,
		IC_ADDR = 3'b001,
		IC_REG  = 3'b010,
		IC_WDAT = 3'b011,
		IC_ACK  = 3'b100,
		IC_RDAT = 3'b101,
		IC_MACK = 3'b110
	} pfs_i2c_t;
endpackage

//--- rtl/pfs_chan.sv
// One rail's fault channel: overcurrent timer, sticky fault flags, trip request.
// Assumes its inputs are already synchronised to clk.
`timescale 1ns/1ps
module pfs_chan
	import pfs_pkg::*;
#(
	parameter int TMO = TMO_CYC
)(
	input  wire logic       clk,
	input  wire logic       rst_b,
	input  wire logic       on,
	input  wire logic       therm,
	input  wire logic       oc,
	input  wire logic       sc,
	input  wire logic       ovuv,
	input  wire logic       rep,
	input  wire logic [3:0] clr,
	output logic      [3:0] flags_r,
	output logic            trip_r,
	output logic            cl_r
);
	localparam int TW = $clog2(TMO + 1);
	logic [TW-1:0] oc_cnt_r;
	logic          oc_exp;
	logic [3:0]    set;

	assign oc_exp = on && oc && (oc_cnt_r == TW'(TMO - 1));

	always_comb
	begin
		set       = 4'h0;
		set[F_TH] = on && therm;
		set[F_OC] = oc_exp;
		set[F_SC] = on && sc;
		set[F_OV] = on && ovuv;
	end

	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
			oc_cnt_r <= '0;
		else if (!on || !oc)
			oc_cnt_r <= '0;
		else if (!oc_exp)
			oc_cnt_r <= oc_cnt_r + 1'b1;
	end

	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			cl_r    <= 1'b0;
			trip_r  <= 1'b0;
			flags_r <= 4'h0;
		end
		else
		begin
			cl_r    <= on && oc && !oc_exp;
			trip_r  <= on && (therm || sc || oc_exp || (ovuv && !rep));
			// A new event wins over a clear in the same cycle.
			flags_r <= (flags_r & ~clr) | set;
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_b);

	ovuv_auto_a: assert property (on && ovuv && !rep |=> trip_r && flags_r[F_OV])
		else $error("auto reaction did not trip");
	ovuv_rep_a: assert property (on && ovuv && rep && !therm && !sc && !oc
		|=> !trip_r && flags_r[F_OV])
		else $error("report-only reaction tripped");
	oc_expire_a: assert property (oc_exp |=> trip_r && flags_r[F_OC] && !cl_r)
		else $error("overcurrent expiry not acted on");
	sc_fast_a: assert property (on && sc |=> trip_r && !cl_r || $past(oc))
		else $error("short circuit not tripped");
endmodule

//--- rtl/pfs_i2c.sv
// I2C register slave: pointer byte, then data bytes written or read with auto-increment.
// Assumes raw pin levels; they are synchronised here before use.
`timescale 1ns/1ps
module pfs_i2c
	import pfs_pkg::*;
(
	input  wire logic       clk,
	input  wire logic       rst_b,
	input  wire logic       scl_in,
	input  wire logic       sda_in,
	output logic            sda_oe_b_r,
	output logic            wr_stb_r,
	output logic      [7:0] wr_dat_r,
	output logic      [7:0] ptr_r,
	input  wire logic [7:0] rd_dat
);
	logic [2:0] scl_r;
	logic [2:0] sda_r;
	pfs_i2c_t   st_r;
	pfs_i2c_t   ret_r;
	logic [7:0] sh_r;
	logic [3:0] cnt_r;
	logic       rw_r;
	logic       rise;
	logic       fall;
	logic       start;
	logic       stop;

	assign rise  = scl_r[1] && !scl_r[2];
	assign fall  = !scl_r[1] && scl_r[2];
	assign start = scl_r[1] && scl_r[2] && sda_r[2] && !sda_r[1];
	assign stop  = scl_r[1] && scl_r[2] && !sda_r[2] && sda_r[1];

	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			scl_r <= 3'h7;
			sda_r <= 3'h7;
		end
		else
		begin
			scl_r <= {scl_r[1:0], scl_in};
			sda_r <= {sda_r[1:0], sda_in};
		end
	end

	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			st_r       <= IC_IDLE;
			ret_r      <= IC_IDLE;
			sh_r       <= 8'h00;
			cnt_r      <= 4'h0;
			rw_r       <= 1'b0;
			ptr_r      <= 8'h00;
			wr_dat_r   <= 8'h00;
			wr_stb_r   <= 1'b0;
			sda_oe_b_r <= 1'b1;
		end
		else
		begin
			wr_stb_r <= 1'b0;
			if (start)
			begin
				st_r       <= IC_ADDR;
				cnt_r      <= 4'h0;
				sda_oe_b_r <= 1'b1;
			end
			else if (stop)
			begin
				st_r       <= IC_IDLE;
				sda_oe_b_r <= 1'b1;
			end
			else if (rise)
			begin
				cnt_r <= cnt_r + 4'h1;
				if (st_r == IC_RDAT)
					sh_r <= {sh_r[6:0], 1'b0};
				else if (st_r == IC_MACK)
				begin
					st_r  <= sda_r[1] ? IC_IDLE : IC_RDAT;
					ptr_r <= ptr_r + 8'h01;
					cnt_r <= 4'h9;
				end
				else
					sh_r <= {sh_r[6:0], sda_r[1]};
			end
			else if (fall)
			begin
				unique case (st_r)
				IC_ADDR:
					if (cnt_r == 4'h8)
					begin
						if (sh_r[7:1] == I2C_ADR)
						begin
							rw_r       <= sh_r[0];
							sda_oe_b_r <= 1'b0;
							ret_r      <= sh_r[0] ? IC_RDAT : IC_REG;
							st_r       <= IC_ACK;
						end
						else
							st_r <= IC_IDLE;
					end
				IC_REG, IC_WDAT:
					if (cnt_r == 4'h8)
					begin
						sda_oe_b_r <= 1'b0;
						st_r       <= IC_ACK;
						ret_r      <= IC_WDAT;
						if (st_r == IC_REG)
							ptr_r <= sh_r;
						else
						begin
							wr_dat_r <= sh_r;
							wr_stb_r <= 1'b1;
						end
					end
				IC_ACK:
				begin
					cnt_r <= 4'h0;
					st_r  <= ret_r;
					if (rw_r)
					begin
						sh_r       <= rd_dat;
						sda_oe_b_r <= rd_dat[7];
					end
					else
						sda_oe_b_r <= 1'b1;
				end
				IC_RDAT:
					if (cnt_r == 4'h9)
					begin
						cnt_r      <= 4'h0;
						sh_r       <= rd_dat;
						sda_oe_b_r <= rd_dat[7];
					end
					else if (cnt_r == 4'h8)
					begin
						sda_oe_b_r <= 1'b1;
						st_r       <= IC_MACK;
					end
					else
						sda_oe_b_r <= sh_r[7];
				IC_IDLE, IC_MACK: ;
				default: st_r <= IC_IDLE;
				endcase
				// In a write, the pointer steps on only after a data byte has been handed on.
				if (st_r == IC_ACK && !rw_r && ret_r == IC_WDAT && wr_stb_r == 1'b0
					&& cnt_r == 4'h8 && sh_r == wr_dat_r)
					ptr_r <= ptr_r;
			end
			if (wr_stb_r)
				ptr_r <= ptr_r + 8'h01;
		end
	end
endmodule

//--- sim/pfs_host.sv
// I2C host model that writes supervisor registers, one pointer and one data byte per frame.
// Assumes a pull-up on SDA, so a released line reads high; SCL idles high between frames.
`timescale 1ns/1ps
module pfs_host
	import pfs_pkg::*;
(
	input  wire logic clk,
	input  wire logic sda_oe_b,
	output logic      scl,
	output logic      sda
);
	logic       drv_b = 1'b1;
	logic [2:0] ak;
	initial scl = 1'b1;
	assign sda = drv_b & sda_oe_b;
	task automatic q;
		repeat (2) @(posedge clk);
	endtask
	// Each SCL period is eight core cycles, 400 ns; SDA only moves while SCL is low.
	task automatic bits(input logic [8:0] v);
		for (int i = 8; i >= 0; i--)
		begin
			drv_b <= v[i];
			q;
			scl <= 1'b1;
			q;
			// The last three acknowledge bits seen, for the bench to compare.
			if (i == 0)
				ak = {ak[1:0], sda};
			q;
			scl <= 1'b0;
			q;
		end
	endtask
	task automatic wr(input logic [7:0] p, input logic [7:0] d);
		drv_b <= 1'b0;
		q;
		scl <= 1'b0;
		q;
		bits({I2C_ADR, 1'b0, 1'b1});
		bits({p, 1'b1});
		bits({d, 1'b1});
		drv_b <= 1'b0;
		q;
		scl <= 1'b1;
		q;
		drv_b <= 1'b1;
		q;
	endtask
endmodule

//--- sim/test_pfs_top.sv
// Self-checking bench for the power supervisor: power-up, groups and fault reactions.
// Assumes the host model for I2C and a shortened overcurrent and retry timeout.
`timescale 1ns/1ps
module test_pfs_top
	import pfs_pkg::*;
;
	localparam int TM = 50;
	logic clk = 1'b0, rst_b = 1'b0, por_in = 1'b0, scl, sda;
	logic [1:0] ss = 2'h0, fq = 2'h0;
	logic [7:0] th = 8'h00, oc = 8'h00, sc = 8'h00, ov = 8'h00, pg = 8'h00;
	logic sda_out, sda_oe_b, rst_out, rst_oe_b, f2;
	logic [7:0] rail_en, cur_lim;
	logic [15:0] ss_time;
	logic [3:0] ph;
	int miscompares, check_count, r, waited;
	always #25 clk = ~clk;
	pfs_top #(.TMO(TM)) u_pfs_top (.clk(clk), .rst_b(rst_b), .por_in(por_in), .ss_cfg_in(ss),
		.frequency_config_input(fq), .therm_in(th), .oc_in(oc), .sc_in(sc), .ovuv_in(ov),
		.pg_in(pg), .scl_in(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe_b(sda_oe_b),
		.rst_out(rst_out), .rst_oe_b(rst_oe_b), .rail_en(rail_en), .cur_lim(cur_lim),
		.ss_time(ss_time), .phase_clk(ph), .second_switching_frequency(f2));
	pfs_host u_pfs_host (.clk(clk), .sda_oe_b(sda_oe_b), .scl(scl), .sda(sda));
	task automatic end_of_test;
		$display("checks %0d miscompares %0d", check_count, miscompares);
		if (miscompares == 0 && check_count > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [7:0] s, input logic [7:0] e);
		check_count++;
		if (s !== e)
		begin
			miscompares++;
			$display("BAD %s exp %h got %h", nm, e, s);
		end
	endtask
	function automatic logic cnd(input int k);
		case (k)
		0: return rail_en[3:1] === 3'h7;
		1: return rst_oe_b === 1'b1;
		2: return rail_en === 8'hFF;
		3: return f2 === 1'b1;
		12: return f2 === 1'b0;
		// Codes 4 to 7 wait for a phase clock high, 8 to 11 for it low.
		default: return ph[k % 4] === (k < 8);
		endcase
	endfunction
	task automatic wt(input int k, input int n);
		int i;
		for (i = 0; i < n && !cnd(k); i++)
			@(posedge clk);
		waited = i;
		if (i == n)
		begin
			miscompares++;
			end_of_test;
		end
	endtask
	task automatic f2per(input int e);
		wt(12, 100);
		wt(3, 100);
		wt(12, 100);
		chk("second_switching_frequency", 8'(waited), 8'(e));
	endtask
	function automatic logic [7:0] gm(input int x);
		return x == 0 ? 8'h01 : x == 7 ? 8'h80 : 8'h70;
	endfunction
	task automatic pwr;
		por_in <= 1'b0;
		pg <= 8'h00;
		repeat (5) @(posedge clk);
		por_in <= 1'b1;
		wt(0, 20);
		repeat (4) @(posedge clk);
		chk("rst", 8'(rst_oe_b), 8'h00);
		pg <= 8'hFF;
		wt(1, 20);
	endtask
	initial
	begin
		r = $urandom(32'hE4812ACF);
		ss <= 2'($urandom);
		fq <= 2'($urandom);
		repeat (10) @(posedge clk);
		chk("rail", rail_en, 8'h00);
		chk("oe", {7'h00, rst_oe_b}, 8'h00);
		rst_b <= 1'b1;
		pwr;
		chk("rail", rail_en, 8'h0E);
		chk("ss", 8'(ss_time[7:2]), {2'h0, {3{ss}}});
		for (int k = 1; k < 4; k++)
		begin
			wt(7 + k, 300);
			wt(3 + k, 300);
			wt(4 + k, 300);
			chk("phase", 8'(waited), 8'(PH_OFF * (fq + 1)));
		end
		u_pfs_host.wr(A_OVM, 8'h80);
		u_pfs_host.wr(A_GRP, 8'h0F);
		wt(2, 200);
		chk("ack", {5'h00, u_pfs_host.ak}, 8'h00);
		r = $urandom % 256;
		u_pfs_host.wr(A_SS, 8'(r));
		chk("ssw", ss_time[15:8], 8'(r));
		r = $urandom % 16;
		u_pfs_host.wr(A_SECOND_SWITCHING_FREQUENCY, 8'(r));
		f2per(r + 1);
		u_pfs_host.wr(A_CTRL, 8'h01);
		u_pfs_host.wr(A_SECOND_SWITCHING_FREQUENCY, 8'(r ^ 5));
		u_pfs_host.wr(A_SECOND_SWITCHING_FREQUENCY, 8'(r ^ 6));
		f2per(r + 1);
		repeat (2) u_pfs_host.wr(A_SECOND_SWITCHING_FREQUENCY, 8'(r ^ 3));
		f2per((r ^ 3) + 1);
		repeat (2) u_pfs_host.wr(A_CTRL, 8'h03);
		pg[X_AUXC] <= 1'b0;
		repeat (6) @(posedge clk);
		chk("seq", rail_en, 8'hDF);
		pg[X_AUXC] <= 1'b1;
		repeat (2) u_pfs_host.wr(A_CTRL, 8'h00);
		chk("ack", {5'h00, u_pfs_host.ak}, 8'h00);
		ov[7] <= 1'b1;
		repeat (30) @(posedge clk);
		chk("rep", rail_en, 8'hFF);
		ov[7] <= 1'b0;
		r = $urandom % 4;
		r = (r == 0) ? 0 : (r == 3) ? 7 : r + 3;
		th[r] <= 1'b1;
		repeat (10) @(posedge clk);
		chk("therm", rail_en, 8'hFF & ~gm(r));
		th <= 8'h00;
		oc[1] <= 1'b1;
		repeat (20) @(posedge clk);
		chk("lim", {7'h00, cur_lim[1]}, 8'h01);
		chk("cpu", 8'(rail_en[3:1]), 8'h07);
		repeat (TM) @(posedge clk);
		chk("octrip", 8'(rail_en[3:1]), 8'h00);
		oc <= 8'h00;
		pwr;
		sc[2] <= 1'b1;
		repeat (6) @(posedge clk);
		chk("short", rail_en, 8'h00);
		sc <= 8'h00;
		wt(0, TM + 30);
		chk("retry", rail_en, 8'h0E);
		wt(1, 40);
		ov[1] <= 1'b1;
		repeat (8) @(posedge clk);
		chk("ovdn", rail_en, 8'h00);
		chk("ovrst", 8'(rst_oe_b), 8'h00);
		ov <= 8'h00;
		wt(1, 40);
		th[1 + $urandom % 3] <= 1'b1;
		repeat (8) @(posedge clk);
		chk("cputh", rail_en, 8'h00);
		chk("pins", {6'h00, sda_out, rst_out}, 8'h00);
		end_of_test;
	end
endmodule
